// File: pkg/fdr_cfg.svh
// Register offsets, field positions, reset values and timing for the fan drive block.
`ifndef FDR_CFG_SVH
`define FDR_CFG_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define FDR_OFS_CONFIG    8'h00
`define FDR_OFS_LOCK      8'h04
`define FDR_OFS_MIN1      8'h08
`define FDR_OFS_MIN2      8'h0C
`define FDR_OFS_DRIVE3_FLOOR_SELECT      8'h10
`define FDR_OFS_STATUS    8'h14
`define FDR_OFS_TACH      8'h18

// ********************************************************************
// Field positions and reset values
// ********************************************************************
`define FDR_BIT_RAMP_EN   3
`define FDR_BIT_SYNC      4
`define FDR_BIT_FLOOR1    5
`define FDR_BIT_LOCK      0
`define FDR_RST_CONFIG    8'h00
`define FDR_RST_MIN       8'h80

// ********************************************************************
// Timing: one ramp slot, so that 1 step per slot covers 33 to 100 percent in 35 s
// ********************************************************************
`define FDR_SLOT_US       204678
`define FDR_CLK_MHZ       50
`define FDR_SLOT_CYC      (`FDR_SLOT_US * `FDR_CLK_MHZ)

// Slot increments per ramp rate code.
`define FDR_INC_0         8'h01
`define FDR_INC_1         8'h02
`define FDR_INC_2         8'h03
`define FDR_INC_3         8'h04
`define FDR_INC_4         8'h08
`define FDR_INC_5         8'h0C
`define FDR_INC_6         8'h18
`define FDR_INC_7         8'h30

`endif

// File: pkg/fdr_pkg.sv
// Types shared by the fan drive ramp and floor control block.
package fdr_pkg;

  // Acoustic ramp and floor configuration register layout.
  typedef struct packed {
    logic       floor3;
    logic       floor2;
    logic       floor1;
    logic       sync;
    logic       ramp_en;
    logic [2:0] rate;
  } fdr_acfg_t;

  // One duty value per drive output, index 0 is drive 1.
  typedef logic [2:0][7:0] fdr_duty3_t;

  // Bus phase of the slave.
  typedef enum logic [0:0] {
    FDR_IDLE,
    FDR_DONE
  } fdr_bus_t;

endpackage : fdr_pkg

// File: rtl/fdr_pwm_chan.sv
// One PWM drive output with duty latched at period start.
`timescale 1ns/1ns
module fdr_pwm_chan (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Duty request
  input  wire logic [7:0] duty,
  // Drive
  output logic            pwm_out,
  output logic            period_start
);

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] duty_lat;
    logic       pwm;
    logic       start;
  } fdr_chan_st_t;

  fdr_chan_st_t st_r;
  fdr_chan_st_t st_nxt;

  // Period is 255 counts, so 0xFF stays high and 0x00 stays low. Duty is taken only
  // at wrap so that a change never cuts a period short.
  always_comb begin
    st_nxt       = st_r;
    st_nxt.start = 1'b0;
    if (st_r.cnt == 8'hFE) begin
      st_nxt.cnt      = 8'h00;
      st_nxt.duty_lat = duty;
      st_nxt.start    = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
    st_nxt.pwm = (st_nxt.cnt < st_nxt.duty_lat); // R8
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pwm_out      = st_r.pwm;
  assign period_start = st_r.start;

endmodule : fdr_pwm_chan

// File: rtl/fdr_top.sv
// Fan drive ramp, floor select and tach sync block with its APB register file.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
`include "fdr_cfg.svh"

// Behaviour
// (R1) Drive 1 steps toward its new duty by the chosen rate code's slot increment.
// (R2) Ramping on drive 1 only while the ramp enable bit 3 is one.
// (R3) Sync bit 4 set ties tach inputs 2, 3 and 4 to drive output 3.
// (R4) Sync bit clear ties only tach inputs 3 and 4; tach 2 runs free.
// (R5) Bit 5 picks off or minimum duty for drive 1 below start temperature.
// (R6) Bit 6 picks off or minimum duty for drive 2 below start temperature.
// (R7) Bit 7 picks off or minimum duty for drive 3 below start temperature.
// (R8) Minimum duty is linear over eight bits: 0x00 off, 0x80 half, 0xFF full.
// (R9) Once the lock bit is set, writes to the configuration register are ignored.
// (R10) Floor and sync changes apply from the next output period onward; floor changes reach the drive outputs only from the period after that.
module fdr_top #(
  parameter int unsigned SLOT_CYC = `FDR_SLOT_CYC
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Fan control loop
  input  wire logic                  auto_mode,
  input  wire logic [2:0]            below_start,
  input  wire fdr_pkg::fdr_duty3_t   calc_duty,
  // Fans
  input  wire logic                  speed_sense_in_2,
  input  wire logic                  speed_sense_in_3,
  input  wire logic                  speed_sense_in_4,
  output logic                       fan_drive_out_1,
  output logic                       fan_drive_out_2,
  output logic                       fan_drive_out_3
);

  // ********************************************************************
  // Parameter check
  // ********************************************************************
  if (SLOT_CYC < 1 || SLOT_CYC > 32'h00FFFFFF) begin : g_bad_slot
    $error("SLOT_CYC must lie between 1 and 2**24-1");
  end

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    fdr_pkg::fdr_acfg_t  acfg;
    logic                lock;
    fdr_pkg::fdr_duty3_t min_duty;
    logic [7:0]          ramp_duty;
    logic [23:0]         slot_cnt;
    logic [2:0]          floor_lat;
    logic                sync_lat;
    logic [2:0]          tach_prev;
    fdr_pkg::fdr_duty3_t tach_cnt;
    fdr_pkg::fdr_bus_t   bus;
    logic [31:0]         rdata;
    logic                slverr;
  } fdr_st_t;

  fdr_st_t             st_r;
  fdr_st_t             st_nxt;
  fdr_pkg::fdr_duty3_t duty_req;
  logic [2:0]          pwm_q;
  logic [2:0]          per_start;
  logic [2:0]          tach_in;
  logic [2:0]          tach_tied;
  logic [7:0]          target1;
  logic [7:0]          step;
  logic                slot_tick;
  logic                bus_done;
  logic                map_hit;
  logic [31:0]         rd_val;

  localparam logic [23:0] SLOT_LAST = 24'(SLOT_CYC - 1);

  // Slot increment for each ramp rate code.
  function automatic logic [7:0] fdr_rate_inc(input logic [2:0] code);
    logic [7:0] inc;
    inc = `FDR_INC_0;
    unique case (code)
      3'h0: inc = `FDR_INC_0;
      3'h1: inc = `FDR_INC_1;
      3'h2: inc = `FDR_INC_2;
      3'h3: inc = `FDR_INC_3;
      3'h4: inc = `FDR_INC_4;
      3'h5: inc = `FDR_INC_5;
      3'h6: inc = `FDR_INC_6;
      3'h7: inc = `FDR_INC_7;
    endcase
    return inc;
  endfunction : fdr_rate_inc

  // ********************************************************************
  // Drive outputs
  // ********************************************************************
  assign tach_in = {speed_sense_in_4, speed_sense_in_3, speed_sense_in_2};

  // Floor choice per output uses the select latched at that output's period start.
  for (genvar i = 0; i < 3; i++) begin : g_chan
    logic [7:0] floor_duty;
    assign floor_duty = st_r.floor_lat[i] ? st_r.min_duty[i] : 8'h00; // R5 R6 R7
    assign duty_req[i] = (i == 0) ? st_r.ramp_duty
                       : ((auto_mode && below_start[i]) ? floor_duty : calc_duty[i]);

    fdr_pwm_chan u_chan (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .duty         (duty_req[i]),
      .pwm_out      (pwm_q[i]),
      .period_start (per_start[i])
    );
  end

  assign fan_drive_out_1 = pwm_q[0];
  assign fan_drive_out_2 = pwm_q[1];
  assign fan_drive_out_3 = pwm_q[2];

  // Drive 1 target before ramping.
  assign target1 = (auto_mode && below_start[0]) ? g_chan[0].floor_duty : calc_duty[0];
  assign step      = fdr_rate_inc(st_r.acfg.rate);
  assign slot_tick = (st_r.slot_cnt == SLOT_LAST);

  // Tach 2 is tied to drive 3 only with sync set; tach 3 and 4 always are.
  assign tach_tied = {1'b1, 1'b1, st_r.sync_lat}; // R3 R4

  // ********************************************************************
  // Register decode
  // ********************************************************************
  assign bus_done = psel && penable && (st_r.bus == fdr_pkg::FDR_DONE);

  // Read mux; unmapped offsets read zero and answer with an error.
  always_comb begin
    rd_val  = 32'h0000_0000;
    map_hit = 1'b1;
    unique case (paddr)
      `FDR_OFS_CONFIG: rd_val = {24'h000000, st_r.acfg};
      `FDR_OFS_LOCK:   rd_val = {31'h00000000, st_r.lock};
      `FDR_OFS_MIN1:   rd_val = {24'h000000, st_r.min_duty[0]};
      `FDR_OFS_MIN2:   rd_val = {24'h000000, st_r.min_duty[1]};
      `FDR_OFS_DRIVE3_FLOOR_SELECT:   rd_val = {24'h000000, st_r.min_duty[2]};
      `FDR_OFS_STATUS: rd_val = {21'h00000, tach_tied, st_r.ramp_duty};
      `FDR_OFS_TACH:   rd_val = {8'h00, st_r.tach_cnt};
      default:         map_hit = 1'b0;
    endcase
  end

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    st_nxt = st_r;

    // APB: one wait cycle, then the completing edge carries the write.
    st_nxt.slverr = 1'b0;
    if (bus_done) begin
      st_nxt.bus = fdr_pkg::FDR_IDLE;
    end else if (psel && penable) begin
      st_nxt.bus    = fdr_pkg::FDR_DONE;
      st_nxt.rdata  = pwrite ? 32'h0000_0000 : rd_val;
      st_nxt.slverr = !map_hit;
    end
    if (bus_done && pwrite && map_hit && !st_r.lock) begin
      unique case (paddr)
        `FDR_OFS_CONFIG: st_nxt.acfg = fdr_pkg::fdr_acfg_t'(pwdata[7:0]); // R9
        `FDR_OFS_MIN1:   st_nxt.min_duty[0] = pwdata[7:0];
        `FDR_OFS_MIN2:   st_nxt.min_duty[1] = pwdata[7:0];
        `FDR_OFS_DRIVE3_FLOOR_SELECT:   st_nxt.min_duty[2] = pwdata[7:0];
        default:         st_nxt.lock = st_r.lock;
      endcase
    end
    // Lock is sticky until reset; once set nothing above is writable.
    if (bus_done && pwrite && (paddr == `FDR_OFS_LOCK) && pwdata[`FDR_BIT_LOCK]) begin
      st_nxt.lock = 1'b1; // R9
    end

    // Floor selects and sync take effect only at a period boundary.
    for (int i = 0; i < 3; i++) begin
      if (per_start[i]) begin
        st_nxt.floor_lat[i] = st_r.acfg[`FDR_BIT_FLOOR1 + i]; // R10
      end
    end
    if (per_start[2]) begin
      st_nxt.sync_lat = st_r.acfg.sync; // R10
    end

    // Slot timer runs freely so the ramp pace does not depend on requests.
    st_nxt.slot_cnt = slot_tick ? 24'h000000 : st_r.slot_cnt + 24'h000001;

    // Drive 1 ramp; without enable the target passes straight through.
    if (!st_r.acfg.ramp_en) begin
      st_nxt.ramp_duty = target1; // R2
    end else if (slot_tick) begin
      if (target1 > st_r.ramp_duty) begin
        st_nxt.ramp_duty = ((target1 - st_r.ramp_duty) > step) ?
                           st_r.ramp_duty + step : target1; // R1
      end else if (target1 < st_r.ramp_duty) begin
        st_nxt.ramp_duty = ((st_r.ramp_duty - target1) > step) ?
                           st_r.ramp_duty - step : target1; // R1
      end
    end

    // Tach edges count only while drive 3 is high when tied; free running otherwise.
    st_nxt.tach_prev = tach_in;
    for (int i = 0; i < 3; i++) begin
      if (tach_in[i] && !st_r.tach_prev[i] && (pwm_q[2] || !tach_tied[i])) begin
        st_nxt.tach_cnt[i] = st_r.tach_cnt[i] + 8'h01; // R3 R4
      end
    end
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r          <= '0;
      st_r.acfg     <= fdr_pkg::fdr_acfg_t'(`FDR_RST_CONFIG);
      st_r.min_duty <= {`FDR_RST_MIN, `FDR_RST_MIN, `FDR_RST_MIN};
      st_r.bus      <= fdr_pkg::FDR_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready  = (st_r.bus == fdr_pkg::FDR_DONE);
  assign prdata  = st_r.rdata;
  // The error flag is only ever set together with the completion state, so it drives the pin alone.
  assign pslverr = st_r.slverr;

endmodule : fdr_top

// File: tb/fdr_top_props.sv
// Checker of the fan drive block port behaviour.
`timescale 1ns/1ns
module fdr_top_props (
  // Clock and reset
  input wire logic                clk,
  input wire logic                sys_rst,
  // APB slave
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  // Control loop and drives
  input wire logic                auto_mode,
  input wire fdr_pkg::fdr_duty3_t calc_duty,
  input wire logic                fan_drive_out_1,
  input wire logic                fan_drive_out_2,
  input wire logic                fan_drive_out_3
);
  logic [9:0]  hold_r;
  logic [15:0] duty_prev_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Counts quiet cycles; a PWM period plus latch lag must pass before a duty shows.
  // A stored copy spots a duty change, so no clock has to be inferred in this process.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_r      <= 10'h000;
      duty_prev_r <= 16'h0000;
    end else begin
      duty_prev_r <= calc_duty[2:1];
      if (auto_mode || (calc_duty[2:1] != duty_prev_r)) hold_r <= 10'h000;
      else if (hold_r != 10'h3FF) hold_r <= hold_r + 10'h001;
    end
  end

  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready stood two cycles.");
  property p_ready_cause; pready |-> psel && penable && $past(psel && penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without access.");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr outside completion.");
  property p_wr_data; pready && pwrite |-> prdata == 32'h00000000; endproperty
  a_wr_data: assert property (p_wr_data) else $error("Write returned read data.");
  property p_unmapped; pready && paddr > 8'h18 |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused.");
  property p_mapped; pready && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("Mapped access refused.");
  property p_rst_low;
    $fell(sys_rst) |-> (!fan_drive_out_1 && !fan_drive_out_2 && !fan_drive_out_3) [*8];
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("Drive high right after reset.");
  property p_full; hold_r >= 10'd520 && calc_duty[1] == 8'hFF |-> fan_drive_out_2; endproperty
  a_full: assert property (p_full) else $error("Full duty not high.");
  property p_off; hold_r >= 10'd520 && calc_duty[2] == 8'h00 |-> !fan_drive_out_3; endproperty
  a_off: assert property (p_off) else $error("Zero duty not low.");
endmodule : fdr_top_props

bind fdr_top fdr_top_props i_fdr_top_props (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .auto_mode(auto_mode), .calc_duty(calc_duty),
  .fan_drive_out_1(fan_drive_out_1), .fan_drive_out_2(fan_drive_out_2),
  .fan_drive_out_3(fan_drive_out_3));

// File: tb/fdr_fan_model.sv
// Behavioural fans that answer with tach pulses.
`timescale 1ns/1ns
module fdr_fan_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Tach lines
  output logic      speed_sense_in_2,
  output logic      speed_sense_in_3,
  output logic      speed_sense_in_4
);
  logic [3:0] cnt_r;

  // Fans spin on inertia, so tach runs at its own rate whatever the drive.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cnt_r <= 4'h0;
    else cnt_r <= cnt_r + 4'h1;
  end

  // Distinct rates keep a crossed tach line visible.
  assign speed_sense_in_2 = cnt_r[1];
  assign speed_sense_in_3 = cnt_r[2];
  assign speed_sense_in_4 = cnt_r[3];
endmodule : fdr_fan_model

// File: tb/fan_drive_ramp_and_floor_control_bench.sv
// Self-checking bench of the fan drive block.
`timescale 1ns/1ns
module fan_drive_ramp_and_floor_control_bench;
  typedef struct packed {
    logic [7:0] a; logic w; logic [31:0] d; logic [31:0] q; logic e;
  } fdr_row_t;
  localparam fdr_row_t ROWS [10] = '{'{8'h00, 0, 0, 0, 0}, '{8'h08, 0, 0, 32'h80, 0},
    '{8'h0C, 0, 0, 32'h80, 0}, '{8'h10, 0, 0, 32'h80, 0}, '{8'h04, 0, 0, 0, 0},
    '{8'h08, 1, 32'hFF, 0, 0}, '{8'h08, 0, 0, 32'hFF, 0}, '{8'h00, 1, 32'hFFFFFF5A, 0, 0},
    '{8'h00, 0, 0, 32'h5A, 0}, '{8'h40, 1, 32'h1, 0, 1}};
  localparam logic [7:0] INC [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};
  localparam logic [7:0] FLR [2] = '{8'hA0, 8'h40};
  localparam int MINV [3] = '{255, 128, 128};
  logic                clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, auto_mode;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rd, t;
  logic [2:0]          below_start;
  logic                s2, s3, s4, out1, out2, out3;
  fdr_pkg::fdr_duty3_t calc_duty;
  int                  failures, comparisons, n, hi [3];

  fdr_top #(.SLOT_CYC(8)) i_fdr_top (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .auto_mode(auto_mode), .below_start(below_start),
    .calc_duty(calc_duty), .speed_sense_in_2(s2), .speed_sense_in_3(s3),
    .speed_sense_in_4(s4), .fan_drive_out_1(out1), .fan_drive_out_2(out2),
    .fan_drive_out_3(out3));
  fdr_fan_model i_fdr_fan_model (.clk(clk), .sys_rst(sys_rst), .speed_sense_in_2(s2),
    .speed_sense_in_3(s3), .speed_sense_in_4(s4));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // One APB transfer; request held until pready is seen at an edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      failures++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Counts high cycles of each drive over one whole PWM period.
  task automatic meas();
    hi = '{0, 0, 0};
    repeat (255) begin
      @(posedge clk);
      hi[0] += int'(out1);
      hi[1] += int'(out2);
      hi[2] += int'(out3);
    end
  endtask : meas

  // Free-running bench clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Main sequence.
  initial begin
    {sys_rst, psel, penable, pwrite, auto_mode, paddr, pwdata} = {1'b1, 44'h0};
    below_start = 3'h0;
    calc_duty = '0;
    failures = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (ROWS[i]) begin
      apb(ROWS[i].a, ROWS[i].w, ROWS[i].d);
      check(rd, ROWS[i].q);
      check(err, ROWS[i].e);
    end
    calc_duty <= {8'h00, 8'hFF, 8'h40};
    apb(8'h00, 1, 32'h00);
    apb(8'h14, 0, 0);
    check(rd[7:0], 8'h40);
    foreach (INC[r]) begin
      calc_duty[0] <= 8'h00;
      apb(8'h00, 1, 32'h00);
      apb(8'h00, 1, 32'(8 + r));
      calc_duty[0] <= 8'hC0;
      n = 0;
      rd = 32'h0;
      while (rd[7:0] == 8'h00 && n < 30) begin
        apb(8'h14, 0, 0);
        n++;
      end
      check(rd[7:0], INC[r]);
    end
    auto_mode <= 1'b1;
    below_start <= 3'h7;
    foreach (FLR[k]) begin
      apb(8'h00, 1, 32'(FLR[k]));
      repeat (520) @(posedge clk);
      meas();
      for (int i = 0; i < 3; i++) check(32'(hi[i]), FLR[k][5 + i] ? 32'(MINV[i]) : 32'h0);
    end
    auto_mode <= 1'b0;
    below_start <= 3'h0;
    for (int s = 1; s >= 0; s--) begin
      apb(8'h00, 1, s ? 32'h10 : 32'h00);
      repeat (300) @(posedge clk);
      apb(8'h14, 0, 0);
      check(rd[10:8], s ? 3'h7 : 3'h6);
      apb(8'h18, 0, 0);
      t = rd;
      repeat (100) @(posedge clk);
      apb(8'h18, 0, 0);
      check(rd[7:0] != t[7:0], s ? 1'b0 : 1'b1);
      check(rd[15:8], t[15:8]);
    end
    // Drive 3 held high: a tied tach line must now count its edges.
    calc_duty[2] <= 8'hFF;
    repeat (520) @(posedge clk);
    apb(8'h18, 0, 0);
    t = rd;
    repeat (100) @(posedge clk);
    apb(8'h18, 0, 0);
    check(rd[15:8] != t[15:8], 1'b1);
    apb(8'h04, 1, 32'h1);
    apb(8'h04, 0, 0);
    check(rd, 32'h01);
    apb(8'h00, 1, 32'hFF);
    apb(8'h00, 0, 0);
    check(rd, 32'h00);
    apb(8'h0C, 1, 32'h11);
    apb(8'h0C, 0, 0);
    check(rd, 32'h80);
    // A second reset in mid-run must clear the sticky lock and restore the defaults.
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(8'h04, 0, 0);
    check(rd, 32'h00);
    apb(8'h08, 0, 0);
    check(rd, 32'h80);
    apb(8'h00, 1, 32'hA5);
    apb(8'h00, 0, 0);
    check(rd, 32'hA5);
    print_verdict();
  end
endmodule : fan_drive_ramp_and_floor_control_bench
